// [logic/dkc_csr_bank.sv]
// Register bank and control/status word of the disk controller
`timescale 1ns/10ps
// Contract
// - Two-bit drive select picks drive 0 to 3; cleared on initialize.
// - Software writes function code run on ready clear; cleared on initialize.
// - Codes 0-7 decode to the eight functions; code 0 plus format selects format.
// - Clearing ready starts a function; ready sets on completion, error or initialize.
// - Interrupt enable gates termination interrupts; read/write, cleared on initialize.
// - A drive attention flag setting raises an interrupt when interrupt enable is set.
// - Drive ready reads clear while a seek runs, set again after.
// - Operation incomplete sets on timeout, header check error or skipped sector.
// - Data check means data ECC error, or header CRC error with incomplete set.
// - Data late means CPU too slow, or header not found with incomplete set.
// - Memory access failure sets nonexistent memory, incomplete and data late.
// - Error bits 13 to 10 clear on initialize or function start.
// - Drive fault follows selected drive but forces no error before ready.
// - Composite error is the OR of bits 14-10; it terminates and interrupts.
// - Per-drive attention on seek done or idle ready change; write one clears.
// - Correction status 00, then 01 on syndrome, then 11 success or 10 failure.
// - Skip sector inhibit suppresses skip sector errors until cleared.
// - Skip sector flag sets on displaced sector header; writable, init clears.
// - Interrupt request bit shows the request line; write one clears.
// - With auto skip disable clear, skip sectors are handled automatically.
// - Timeout disable stops the operation timeout counter.
// - Writing minus one to the reset trigger initializes the whole controller; the code keeps the drive pin pipeline and filtered drive flags.
// - Attention write mask stops control/status writes clearing attention flags.
module dkc_csr_bank #(
	parameter int unsigned TIMEOUT_CYCLES = dkc_pkg::OPI_TIMEOUT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [23:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire dkc_pkg::dkc_seq_evt_t seqEvt,
	input wire dkc_pkg::dkc_drv_pins_t drvPins,
	input wire logic [12:0] corrPosition,
	input wire logic [10:0] corrPattern,
	output dkc_pkg::dkc_seq_ctl_t seqCtl,
	output logic [31:0] byteCount,
	output logic [31:0] memStart,
	output logic [31:0] diskLoc,
	output logic [31:0] statusCmd,
	output logic busIrq
);
	typedef struct packed {
		dkc_pkg::dkc_ctl_t ctl;
		logic [2:0] func;
		logic ie;
		logic [1:0] ds;
		logic operation_incomplete;
		logic data_check;
		logic data_late;
		logic nonexistent_memory;
		logic de;
		logic [3:0] attn;
		logic [1:0] ecs;
		logic skip_sector_inhibit;
		logic skip_sector_flag;
		logic ir;
		logic maintenance_mode;
		logic auto_skip_disable;
		logic timeout_disable;
		logic fmt;
		logic mask;
		logic [3:0] seekBusy;
		dkc_pkg::dkc_drv_pins_t s1;
		dkc_pkg::dkc_drv_pins_t s2;
		dkc_pkg::dkc_drv_pins_t s3;
		logic [3:0] readyF;
		logic [3:0] seekF;
		logic [3:0] faultF;
		logic [31:0] byteCount;
		logic [31:0] memStart;
		logic [31:0] diskLoc;
		logic [31:0] statusCmd;
		logic [31:0] resetTrig;
		logic [31:0] rdata;
		logic ack;
		logic start;
		logic abort;
	} dkc_bank_t;
	localparam dkc_bank_t RESET_ST = '{ctl: dkc_pkg::CTL_IDLE, default: '0};
	dkc_bank_t st;
	dkc_bank_t next_st;
	logic req;
	logic wrReq;
	logic wrCsr;
	logic idle;
	logic running;
	logic softInit;
	logic startReq;
	logic skipErr;
	logic errEvt;
	logic expired;
	logic drive_ready_flag;
	logic errBit;
	logic [3:0] newReady;
	logic [3:0] newSeek;
	logic [3:0] newFault;
	logic [3:0] seekEdge;
	logic [3:0] readyChg;
	logic [3:0] attnSet;
	logic [3:0] attnClr;
	logic [31:0] csrView;
	// Take a synchronised level only once stages two and three agree
	function automatic logic [3:0] dkc_filter(input logic [3:0] old, input logic [3:0] a,
		input logic [3:0] b);
		return (old & (a ^ b)) | (b & ~(a ^ b));
	endfunction
	// Byte-lane merge of a 32-bit write
	function automatic logic [31:0] dkc_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction
	// Bus request decode
	assign req = cyc_i & stb_i & ~st.ack;
	assign wrReq = req & we_i;
	assign wrCsr = wrReq && (adr_i == dkc_pkg::ADDR_CONTROL_STATUS);
	assign idle = st.ctl == dkc_pkg::CTL_IDLE;
	assign running = st.ctl == dkc_pkg::CTL_RUN;
	assign softInit = wrReq && (adr_i == dkc_pkg::ADDR_RESET_TRIG) && (sel_i == 4'hF)
		&& (dat_i == dkc_pkg::RESET_TRIGGER_VALUE);
	assign startReq = wrCsr & sel_i[0] & idle & ~dat_i[dkc_pkg::CS_CONTROLLER_READY];
	// Filtered drive pins and their events
	assign newReady = dkc_filter(st.readyF, st.s2.ready, st.s3.ready);
	assign newSeek = dkc_filter(st.seekF, st.s2.seekDone, st.s3.seekDone);
	assign newFault = dkc_filter(st.faultF, st.s2.fault, st.s3.fault);
	assign seekEdge = newSeek & ~st.seekF;
	assign readyChg = newReady ^ st.readyF;
	// Seek completion, or ready change while idle and not seeking
	assign attnSet = (seekEdge & st.seekBusy) | ({4{idle}} & readyChg & ~st.seekBusy);
	assign attnClr = (wrCsr && sel_i[2] && !st.mask) ? dat_i[19:16] : 4'h0;
	// Skip sector errors count only under software control and when not inhibited
	assign skipErr = seqEvt.displacedSector & st.auto_skip_disable & ~st.skip_sector_inhibit;
	assign errEvt = running & (seqEvt.hdrCrcErr | seqEvt.hdrNotFound | seqEvt.dataEccErr
		| seqEvt.dataLate | seqEvt.memFault | skipErr | expired);
	// Status word view
	assign drive_ready_flag = st.readyF[st.ds] & ~st.seekBusy[st.ds];
	assign errBit = st.operation_incomplete | st.data_check | st.data_late | st.nonexistent_memory | (st.de & idle);
	assign csrView = {st.mask, 1'b0, st.fmt, st.timeout_disable, st.auto_skip_disable, 1'b0, st.maintenance_mode, st.ir,
		st.skip_sector_flag, st.skip_sector_inhibit, st.ecs, st.attn, errBit, st.de, st.nonexistent_memory, st.data_late, st.data_check, st.operation_incomplete,
		st.ds, idle, st.ie, 2'b00, st.func, drive_ready_flag};
	// Operation timeout, held off by the disable bit
	dkc_op_timer #(
		.CYCLES(TIMEOUT_CYCLES)
	) u_timer (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.clear(startReq | softInit),
		.run(running & ~st.timeout_disable),
		.expired(expired)
	);

	// Next state of the whole bank
	always_comb begin
		next_st = st;
		next_st.start = 1'b0;
		next_st.abort = 1'b0;
		next_st.ack = req;
		// Registered read data
		if (req && !we_i) begin
			unique case (adr_i)
				dkc_pkg::ADDR_CONTROL_STATUS: next_st.rdata = csrView;
				dkc_pkg::ADDR_BYTE_COUNT: next_st.rdata = st.byteCount;
				dkc_pkg::ADDR_MEM_START: next_st.rdata = st.memStart;
				dkc_pkg::ADDR_DISK_LOC: next_st.rdata = st.diskLoc;
				dkc_pkg::ADDR_STATUS_CMD: next_st.rdata = st.statusCmd;
				dkc_pkg::ADDR_CORR_POS: next_st.rdata = {19'h0, corrPosition};
				dkc_pkg::ADDR_CORR_PAT: next_st.rdata = {21'h0, corrPattern};
				dkc_pkg::ADDR_RESET_TRIG: next_st.rdata = st.resetTrig;
				default: next_st.rdata = 32'h0;
			endcase
		end
		// Pin synchronisers, three stages
		next_st.s1 = drvPins;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.readyF = newReady;
		next_st.seekF = newSeek;
		next_st.faultF = newFault;
		// Plain read/write registers
		if (wrReq && adr_i == dkc_pkg::ADDR_BYTE_COUNT) begin
			next_st.byteCount = dkc_merge(st.byteCount, dat_i, sel_i);
		end
		if (wrReq && adr_i == dkc_pkg::ADDR_MEM_START) begin
			next_st.memStart = dkc_merge(st.memStart, dat_i, sel_i);
		end
		if (wrReq && adr_i == dkc_pkg::ADDR_DISK_LOC) begin
			next_st.diskLoc = dkc_merge(st.diskLoc, dat_i, sel_i);
		end
		if (wrReq && adr_i == dkc_pkg::ADDR_STATUS_CMD) begin
			next_st.statusCmd = dkc_merge(st.statusCmd, dat_i, sel_i);
		end
		if (wrReq && adr_i == dkc_pkg::ADDR_RESET_TRIG) begin
			next_st.resetTrig = dkc_merge(st.resetTrig, dat_i, sel_i);
		end
		// Software writes to the control/status word
		if (wrCsr && sel_i[0]) begin
			next_st.func = dat_i[dkc_pkg::CS_FUNC_LO +: 3];
			next_st.ie = dat_i[dkc_pkg::CS_IE];
		end
		if (wrCsr && sel_i[1]) begin
			next_st.ds = dat_i[dkc_pkg::CS_DS_LO +: 2];
		end
		if (wrCsr && sel_i[2]) begin
			next_st.skip_sector_inhibit = dat_i[dkc_pkg::CS_SKIP_SECTOR_INHIBIT];
			next_st.skip_sector_flag = dat_i[dkc_pkg::CS_SSE];
		end
		if (wrCsr && sel_i[3]) begin
			next_st.maintenance_mode = dat_i[dkc_pkg::CS_MTN];
			next_st.auto_skip_disable = dat_i[dkc_pkg::CS_AUTO_SKIP_DISABLE];
			next_st.timeout_disable = dat_i[dkc_pkg::CS_TOI];
			next_st.fmt = dat_i[dkc_pkg::CS_FMT];
			next_st.mask = dat_i[dkc_pkg::CS_MASK];
			next_st.ir = st.ir & ~dat_i[dkc_pkg::CS_IR];
		end
		next_st.attn = st.attn & ~attnClr;
		// Launch: ready cleared by software, errors of the last function dropped
		if (startReq) begin
			next_st.ctl = dkc_pkg::CTL_RUN;
			next_st.start = 1'b1;
			next_st.operation_incomplete = 1'b0;
			next_st.data_check = 1'b0;
			next_st.data_late = 1'b0;
			next_st.nonexistent_memory = 1'b0;
			next_st.ecs = dkc_pkg::ECS_NONE;
			if (dkc_pkg::dkc_decode(next_st.fmt, next_st.func) == dkc_pkg::CMD_SEEK) begin
				next_st.seekBusy[next_st.ds] = 1'b1;
			end
		end
		// Drive events
		next_st.seekBusy = next_st.seekBusy & ~seekEdge;
		next_st.de = newFault[next_st.ds];
		// Error capture while a function runs
		if (running) begin
			if (expired) begin
				next_st.operation_incomplete = 1'b1;
			end
			if (seqEvt.hdrCrcErr) begin
				next_st.operation_incomplete = 1'b1;
				next_st.data_check = 1'b1;
			end
			if (seqEvt.hdrNotFound) begin
				next_st.operation_incomplete = 1'b1;
				next_st.data_late = 1'b1;
			end
			next_st.data_check = next_st.data_check | seqEvt.dataEccErr;
			next_st.data_late = next_st.data_late | seqEvt.dataLate;
			if (seqEvt.memFault) begin
				next_st.nonexistent_memory = 1'b1;
				next_st.operation_incomplete = 1'b1;
				next_st.data_late = 1'b1;
			end
			if (skipErr) begin
				next_st.skip_sector_flag = 1'b1;
				next_st.operation_incomplete = 1'b1;
			end
		end
		// Correction status progression
		if (seqEvt.syndromeNonzero && st.ecs == dkc_pkg::ECS_NONE) begin
			next_st.ecs = dkc_pkg::ECS_BUSY;
		end else if (seqEvt.correctOk && st.ecs == dkc_pkg::ECS_BUSY) begin
			next_st.ecs = dkc_pkg::ECS_FIXED;
		end else if (seqEvt.correctFail && st.ecs == dkc_pkg::ECS_BUSY) begin
			next_st.ecs = dkc_pkg::ECS_HARD;
		end
		// Termination, normal or by error
		if (running && (seqEvt.done || errEvt)) begin
			next_st.ctl = dkc_pkg::CTL_IDLE;
			next_st.abort = errEvt;
			next_st.ir = next_st.ir | st.ie;
		end
		// Attention flags, hardware set wins over software clear
		next_st.attn = next_st.attn | attnSet;
		next_st.ir = next_st.ir | ((|attnSet) & st.ie);
		// Initialize through the reset trigger keeps the pin pipeline
		if (softInit) begin
			next_st = RESET_ST;
			next_st.s1 = st.s1;
			next_st.s2 = st.s2;
			next_st.s3 = st.s3;
			next_st.readyF = st.readyF;
			next_st.seekF = st.seekF;
			next_st.faultF = st.faultF;
			next_st.ack = 1'b1;
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st <= RESET_ST;
		end else begin
			st <= next_st;
		end
	end

	// Outputs
	assign dat_o = st.rdata;
	assign ack_o = st.ack;
	assign busIrq = st.ir;
	assign byteCount = st.byteCount;
	assign memStart = st.memStart;
	assign diskLoc = st.diskLoc;
	assign statusCmd = st.statusCmd;
	assign seqCtl.start = st.start;
	assign seqCtl.abort = st.abort;
	assign seqCtl.command = dkc_pkg::dkc_decode(st.fmt, st.func);
	assign seqCtl.driveSel = st.ds;
	assign seqCtl.maintenance = st.maintenance_mode;
	assign seqCtl.skipManual = st.auto_skip_disable;
	assign seqCtl.skipInhibit = st.skip_sector_inhibit;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	chk_init_drive_sel: assert property (softInit |=> st.ds == 2'h0 && st.func == 3'h0)
		else $error("drive select or function not cleared by initialize");
	chk_format_decode: assert property (st.fmt && st.func == 3'h0
		|-> seqCtl.command == dkc_pkg::CMD_FORMAT)
		else $error("format select not decoded");
	chk_done_ready: assert property (running && seqEvt.done && !softInit |=> idle)
		else $error("ready not set at completion");
	chk_start_runs: assert property (startReq && !softInit |=> running ##0 st.start)
		else $error("function not started when ready cleared");
	chk_end_irq: assert property (running && seqEvt.done && st.ie && !softInit |=> busIrq)
		else $error("no interrupt at termination");
	chk_attn_irq: assert property ((|attnSet) && st.ie && !softInit |=> busIrq)
		else $error("no interrupt on attention");
	chk_seek_drive_ready_flag: assert property (st.seekBusy[st.ds] |-> !csrView[0])
		else $error("drive ready shown during seek");
	chk_timeout_opi: assert property (running && expired && !softInit |=> st.operation_incomplete && idle)
		else $error("timeout did not set incomplete");
	chk_nxm_flags: assert property (running && seqEvt.memFault && !softInit
		|=> st.nonexistent_memory && st.operation_incomplete && st.data_late)
		else $error("memory fault flags wrong");
	chk_start_clears: assert property ($rose(st.start) |-> !(st.operation_incomplete | st.data_check | st.data_late | st.nonexistent_memory))
		else $error("errors not cleared at start");
	chk_fault_no_err: assert property (running && !(st.operation_incomplete | st.data_check | st.data_late | st.nonexistent_memory)
		|-> !csrView[15])
		else $error("drive fault forced error early");
	chk_ecs_success: assert property (st.ecs == dkc_pkg::ECS_BUSY && seqEvt.correctOk && !startReq
		&& !softInit |=> st.ecs == dkc_pkg::ECS_FIXED)
		else $error("correction status did not reach 11");
endmodule

// [logic/dkc_op_timer.sv]
// Operation timeout counter of the disk controller
`timescale 1ns/10ps
module dkc_op_timer #(
	parameter int unsigned CYCLES = dkc_pkg::OPI_TIMEOUT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clear,
	input wire logic run,
	output logic expired
);
	typedef struct packed {
		logic [31:0] count;
		logic fired;
		logic pulse;
	} dkc_timer_t;

	dkc_timer_t st;
	dkc_timer_t next_st;

	// Count while running, pulse once at the limit
	always_comb begin
		next_st = st;
		next_st.pulse = 1'b0;
		if (clear) begin
			next_st.count = 32'h0;
			next_st.fired = 1'b0;
		end else if (run && !st.fired) begin
			if (st.count == 32'(CYCLES - 1)) begin
				next_st.fired = 1'b1;
				next_st.pulse = 1'b1;
			end else begin
				next_st.count = st.count + 32'h1;
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign expired = st.pulse;
endmodule

// [logic/dkc_pkg.sv]
// Constants, field positions and carrier types of the disk controller register bank
package dkc_pkg;
	// Register byte addresses
	localparam logic [23:0] ADDR_BYTE_COUNT = 24'h0F2608;
	localparam logic [23:0] ADDR_CONTROL_STATUS = 24'hF26200;
	localparam logic [23:0] ADDR_MEM_START = 24'hF26204;
	localparam logic [23:0] ADDR_DISK_LOC = 24'hF2620C;
	localparam logic [23:0] ADDR_STATUS_CMD = 24'hF26210;
	localparam logic [23:0] ADDR_CORR_POS = 24'hF26214;
	localparam logic [23:0] ADDR_CORR_PAT = 24'hF26218;
	localparam logic [23:0] ADDR_RESET_TRIG = 24'hF2621C;
	localparam logic [31:0] RESET_TRIGGER_VALUE = 32'hFFFFFFFF;

	// Control/status word field positions
	localparam int CS_FUNC_LO = 1;
	localparam int CS_IE = 6;
	localparam int CS_CONTROLLER_READY = 7;
	localparam int CS_DS_LO = 8;
	localparam int CS_ATTN_LO = 16;
	localparam int CS_SKIP_SECTOR_INHIBIT = 22;
	localparam int CS_SSE = 23;
	localparam int CS_IR = 24;
	localparam int CS_MTN = 25;
	localparam int CS_AUTO_SKIP_DISABLE = 27;
	localparam int CS_TOI = 28;
	localparam int CS_FMT = 29;
	localparam int CS_MASK = 31;

	// Correction status codes
	localparam logic [1:0] ECS_NONE = 2'h0;
	localparam logic [1:0] ECS_BUSY = 2'h1;
	localparam logic [1:0] ECS_HARD = 2'h2;
	localparam logic [1:0] ECS_FIXED = 2'h3;

	// Operation timeout
	localparam int unsigned OPI_TIMEOUT_MS = 150;
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned OPI_TIMEOUT_CYCLES = OPI_TIMEOUT_MS * (CLK_HZ / 1000);

	typedef enum logic [1:0] {
		CTL_IDLE = 2'h1,
		CTL_RUN = 2'h2
	} dkc_ctl_t;

	typedef enum logic [8:0] {
		CMD_NOP = 9'h001,
		CMD_WRITE_CHECK = 9'h002,
		CMD_GET_STATUS = 9'h004,
		CMD_SEEK = 9'h008,
		CMD_READ_HEADER = 9'h010,
		CMD_WRITE_DATA = 9'h020,
		CMD_READ_DATA = 9'h040,
		CMD_READ_NO_HDR = 9'h080,
		CMD_FORMAT = 9'h100
	} dkc_cmd_t;

	// Events from the microsequencer and data path, one-cycle pulses
	typedef struct packed {
		logic done;
		logic hdrCrcErr;
		logic hdrNotFound;
		logic dataEccErr;
		logic dataLate;
		logic memFault;
		logic displacedSector;
		logic syndromeNonzero;
		logic correctOk;
		logic correctFail;
	} dkc_seq_evt_t;

	// Drive status pins, one bit per drive
	typedef struct packed {
		logic [3:0] ready;
		logic [3:0] seekDone;
		logic [3:0] fault;
	} dkc_drv_pins_t;

	// Control towards the microsequencer
	typedef struct packed {
		logic start;
		logic abort;
		dkc_cmd_t command;
		logic [1:0] driveSel;
		logic maintenance;
		logic skipManual;
		logic skipInhibit;
	} dkc_seq_ctl_t;

	// Function code and format select to command
	function automatic dkc_cmd_t dkc_decode(input logic fmt, input logic [2:0] code);
		dkc_cmd_t cmd;
		cmd = CMD_NOP;
		unique case (code)
			3'h0: cmd = fmt ? CMD_FORMAT : CMD_NOP;
			3'h1: cmd = CMD_WRITE_CHECK;
			3'h2: cmd = CMD_GET_STATUS;
			3'h3: cmd = CMD_SEEK;
			3'h4: cmd = CMD_READ_HEADER;
			3'h5: cmd = CMD_WRITE_DATA;
			3'h6: cmd = CMD_READ_DATA;
			3'h7: cmd = CMD_READ_NO_HDR;
		endcase
		return cmd;
	endfunction
endpackage

// [testbench/dkc_csr_bank_tb.sv]
// Self-checking bench of the disk controller register bank
`timescale 1ns/10ps
module dkc_csr_bank_tb;
	localparam int unsigned TMO = 20;
	localparam logic [23:0] CS = dkc_pkg::ADDR_CONTROL_STATUS;
	localparam logic [23:0] TRIG = dkc_pkg::ADDR_RESET_TRIG;
	localparam logic [12:0] POS = 13'h0ABC;
	localparam logic [10:0] PAT = 11'h5A3;
	logic sys_clk, nrst, cyc, stb, we, ack, startSeen, busIrq;
	logic [23:0] adr;
	logic [3:0] sel;
	logic [31:0] datW, datR, rd, byteCount, memStart, diskLoc, statusCmd;
	logic [1:0] mode;
	logic [23:0] rwAddr [4];
	dkc_pkg::dkc_seq_evt_t seqEvt;
	dkc_pkg::dkc_drv_pins_t drvPins;
	dkc_pkg::dkc_seq_ctl_t seqCtl;
	int errors, n_checks;

	dkc_csr_bank #(.TIMEOUT_CYCLES(TMO)) DUT (.sys_clk(sys_clk), .nrst(nrst), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR),
		.ack_o(ack), .seqEvt(seqEvt), .drvPins(drvPins), .corrPosition(POS),
		.corrPattern(PAT), .seqCtl(seqCtl), .byteCount(byteCount), .memStart(memStart),
		.diskLoc(diskLoc), .statusCmd(statusCmd), .busIrq(busIrq));

	dkc_seq_model seqModel (.sys_clk(sys_clk), .nrst(nrst), .seqCtl(seqCtl), .mode(mode),
		.seqEvt(seqEvt), .drvPins(drvPins));

	// ****************************************
	// Bus tasks and comparison
	// ****************************************
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One classic cycle; held until ack is seen, released at that edge
	task automatic bus(input logic w, input logic [23:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		datW <= d;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			errors++;
			end_sim();
		end
		rd = datR;
		startSeen = seqCtl.start;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	// Polls the control word until the ready bit returns
	task automatic wait_rdy();
		int n;
		n = 0;
		rd = 32'h0;
		while (rd[7] !== 1'b1 && n < 30) begin
			bus(1'b0, CS, 32'h0);
			n++;
		end
		if (rd[7] !== 1'b1) begin
			errors++;
			end_sim();
		end
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		nrst = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 24'h000000;
		sel = 4'h0;
		datW = 32'h0;
		mode = 2'h0;
		errors = 0;
		n_checks = 0;
		rwAddr = '{dkc_pkg::ADDR_MEM_START, dkc_pkg::ADDR_BYTE_COUNT, dkc_pkg::ADDR_DISK_LOC,
			dkc_pkg::ADDR_STATUS_CMD};
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		bus(1'b0, CS, 32'h0);
		chk("reset control word", 32'h00000080, rd);
		bus(1'b0, TRIG, 32'h0);
		chk("reset trigger", 32'h0, rd);
		// Plain storage: reset value, write, read back
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, rwAddr[i], 32'h0);
			chk("reset storage", 32'h0, rd);
			bus(1'b1, rwAddr[i], 32'hA5C30F10 + 32'(i));
			bus(1'b0, rwAddr[i], 32'h0);
			chk("storage readback", 32'hA5C30F10 + 32'(i), rd);
		end
		chk("memStart", 32'hA5C30F10, memStart);
		chk("byteCount", 32'hA5C30F11, byteCount);
		chk("diskLoc", 32'hA5C30F12, diskLoc);
		chk("statusCmd", 32'hA5C30F13, statusCmd);
		bus(1'b1, dkc_pkg::ADDR_CORR_POS, 32'hFFFFFFFF);
		bus(1'b0, dkc_pkg::ADDR_CORR_POS, 32'h0);
		chk("correction position", {19'h0, POS}, rd);
		bus(1'b1, dkc_pkg::ADDR_CORR_PAT, 32'hFFFFFFFF);
		bus(1'b0, dkc_pkg::ADDR_CORR_PAT, 32'h0);
		chk("correction pattern", {21'h0, PAT}, rd);
		bus(1'b1, 24'hF26220, 32'h12345678);
		bus(1'b0, 24'hF26220, 32'h0);
		chk("unmapped read", 32'h0, rd);
		// Every function code, ready left set so nothing launches
		for (int i = 0; i < 9; i++) begin
			bus(1'b1, CS, 32'h80 | ((i == 8) ? 32'h20000000 : (32'(i) << 1)));
			chk("start while ready", 32'h0, {31'h0, startSeen});
			chk("command", (i == 8) ? 32'h100 : (32'h1 << i), {23'h0, seqCtl.command});
		end
		// Read data on drive 2 with interrupts on
		bus(1'b1, CS, 32'h0000024C);
		chk("start pulse", 32'h1, {31'h0, startSeen});
		chk("drive select", 32'h2, {30'h0, seqCtl.driveSel});
		wait_rdy();
		chk("done status", 32'h010002CC, rd);
		chk("irq line", 32'h1, {31'h0, busIrq});
		bus(1'b1, CS, 32'h010002CC);
		bus(1'b0, CS, 32'h0);
		chk("irq cleared", 32'h000002CC, rd);
		chk("irq line low", 32'h0, {31'h0, busIrq});
		// Header check failure with interrupts off
		mode <= 2'h1;
		bus(1'b1, CS, 32'h0000020C);
		wait_rdy();
		chk("header error", 32'h00008E8C, rd);
		chk("irq masked", 32'h0, {31'h0, busIrq});
		mode <= 2'h0;
		bus(1'b1, CS, 32'h0000020C);
		wait_rdy();
		chk("errors cleared", 32'h0000028C, rd);
		// Sequencer silent: timeout ends it, then timeout disabled
		mode <= 2'h2;
		bus(1'b1, CS, 32'h0000020C);
		wait_rdy();
		chk("timeout", 32'h0000868C, rd);
		bus(1'b1, CS, 32'h1000020C);
		repeat (2 * TMO) @(posedge sys_clk);
		bus(1'b0, CS, 32'h0);
		chk("no timeout", 32'h1000020C, rd);
		bus(1'b1, TRIG, 32'hFFFFFFFE);
		chk("no init", 32'hA5C30F10, memStart);
		bus(1'b1, TRIG, dkc_pkg::RESET_TRIGGER_VALUE);
		bus(1'b0, CS, 32'h0);
		chk("init control word", 32'h00000080, rd);
		chk("init storage", 32'h0, memStart);
		// Seek on drive 1 raises attention; mask blocks its clearing
		mode <= 2'h0;
		bus(1'b1, CS, 32'h00000146);
		wait_rdy();
		repeat (10) @(posedge sys_clk);
		bus(1'b0, CS, 32'h0);
		chk("seek attention", 32'h010201C6, rd);
		bus(1'b1, CS, 32'h800001C6);
		bus(1'b1, CS, 32'h800201C6);
		bus(1'b0, CS, 32'h0);
		chk("masked clear", 32'h810201C6, rd);
		bus(1'b1, CS, 32'h000201C6);
		bus(1'b1, CS, 32'h000201C6);
		bus(1'b0, CS, 32'h0);
		chk("attention cleared", 32'h010001C6, rd);
		// Memory fault with a correctable syndrome; drive 2 turns ready and faulty
		mode <= 2'h3;
		bus(1'b1, CS, 32'h0000020C);
		wait_rdy();
		repeat (10) @(posedge sys_clk);
		bus(1'b0, CS, 32'h0);
		chk("fault status", 32'h0134F68D, rd);
		bus(1'b1, CS, 32'h0A40028C);
		chk("sequencer modes", 32'h7, {29'h0, seqCtl[2:0]});
		end_sim();
	end
endmodule

// [testbench/dkc_seq_model.sv]
// Stand-in for the microsequencer and the drives behind the register bank
`timescale 1ns/10ps
module dkc_seq_model (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire dkc_pkg::dkc_seq_ctl_t seqCtl,
	input wire logic [1:0] mode,
	output dkc_pkg::dkc_seq_evt_t seqEvt,
	output dkc_pkg::dkc_drv_pins_t drvPins
);
	logic [3:0] count;
	logic busy;
	logic fixPend;

	// Waits a few cycles after each launch, then ends the function as mode asks
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			count <= 4'h0;
			busy <= 1'b0;
			fixPend <= 1'b0;
			seqEvt <= '0;
			drvPins <= '0;
		end else begin
			seqEvt <= '0;
			seqEvt.correctOk <= fixPend;
			fixPend <= 1'b0;
			if (seqCtl.start) begin
				busy <= 1'b1;
				count <= 4'h5;
				drvPins.seekDone <= 4'h0;
			end else if (busy && count != 4'h0) begin
				count <= count - 4'h1;
			end else if (busy) begin
				busy <= 1'b0;
				seqEvt.done <= (mode == 2'h0);
				seqEvt.hdrCrcErr <= (mode == 2'h1);
				seqEvt.memFault <= (mode == 2'h3);
				seqEvt.syndromeNonzero <= (mode == 2'h3);
				fixPend <= (mode == 2'h3);
				// Fault run also brings the selected drive ready and faulty
				if (mode == 2'h3) begin
					drvPins.ready[seqCtl.driveSel] <= 1'b1;
					drvPins.fault[seqCtl.driveSel] <= 1'b1;
				end
				// Seek completion shows as a rising level on the selected drive
				if (mode == 2'h0 && seqCtl.command == dkc_pkg::CMD_SEEK) begin
					drvPins.seekDone[seqCtl.driveSel] <= 1'b1;
				end
			end
		end
	end
endmodule
